// ==== rtl/dsb_bus_access.sv ====
// system bus access path: address and data registers, bus master sequencing
// ==========================================================
// Functional notes
// - 32-bit bus address register, reset zero, gives every access address.
// - 32-bit low data register, reset zero, holds lower data bits.
// - 32-bit high data register, reset zero, holds data bits 63 to 32.
// - successful read loads both data registers with bus read data.
// - data bits above a narrow read width are don't-care.
// - accesses start only while error code and busy-violation are zero.
// - debugger read of low data starts bus read when read-on-data is set, write starts bus write.
// - high data register accesses never start a bus access.
// - data register access while busy sets busy-violation and is aborted.
// - closely coupled memories and interrupt controller range unreachable here.
// - registers reachable at their debug module interface offsets.
// - busy set when access requested, held until fully completed.
// - read-on-address-write starts a read at each newly written address.
// - auto-step adds access size in bytes to address after each access completed without bus error.
// - read-on-data-read starts a read after each low data read.
`timescale 1ns/1ns
`default_nettype none
module dsb_bus_access #(
  parameter logic [31:0] closely_coupled_instruction_memory_base = 32'hE000_0000,
  parameter logic [31:0] closely_coupled_instruction_memory_mask = 32'hFF00_0000,
  parameter logic [31:0] closely_coupled_data_memory_base = 32'hF000_0000,
  parameter logic [31:0] closely_coupled_data_memory_mask = 32'hFF00_0000,
  parameter logic [31:0] interrupt_controller_range_base = 32'hD000_0000,
  parameter logic [31:0] interrupt_controller_range_mask = 32'hFF00_0000
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire dsb_pkg::dsb_dmi_req_s dmi_req_i,
  output var dsb_pkg::dsb_dmi_rsp_s dmi_rsp_o,
  input wire dsb_pkg::dsb_ctrl_s ctrl_i,
  input wire logic busy_error_clr_i,
  input wire logic error_clr_i,
  output var dsb_pkg::dsb_stat_s stat_o,
  output var dsb_pkg::dsb_sb_req_s sb_req_o,
  input wire dsb_pkg::dsb_sb_rsp_s sb_rsp_i
);
  import dsb_pkg::*;

  // ==========================================================
  // state
  dsb_state_e state_r, state_nxt;
  logic [31:0] bus_address_reg_r;
  logic [31:0] bus_data_low_reg_r;
  logic [31:0] bus_data_high_reg_r;
  logic busy_error_r;
  logic [2:0] error_r;
  dsb_sb_req_s sb_req_r;
  dsb_dmi_rsp_s dmi_rsp_r;

  // ==========================================================
  // register decode
  wire hit_addr = dmi_req_i.valid && (dmi_req_i.addr == ADDR_BUS_ADDRESS);
  wire hit_low = dmi_req_i.valid && (dmi_req_i.addr == ADDR_DATA_LOW);
  wire hit_high = dmi_req_i.valid && (dmi_req_i.addr == ADDR_DATA_HIGH);
  wire busy = (state_r == DSB_BUSY);
  wire gate_open = (error_r == ERR_NONE) && !busy_error_r;
  wire addr_wr = hit_addr && dmi_req_i.write;
  wire low_wr = hit_low && dmi_req_i.write;
  wire low_rd = hit_low && !dmi_req_i.write;
  wire data_violation = (hit_low || hit_high) && busy;
  wire addr_violation = addr_wr && busy && ctrl_i.read_on_addr;
  wire set_busy_error = data_violation || addr_violation;

  // ==========================================================
  // access request
  wire want_read = !busy && ((addr_wr && ctrl_i.read_on_addr)
    || (low_rd && ctrl_i.read_on_data));
  wire want_write = !busy && low_wr;
  wire want = (want_read || want_write) && gate_open;
  wire [31:0] start_addr = addr_wr ? dmi_req_i.wdata : bus_address_reg_r;
  wire [31:0] start_low = low_wr ? dmi_req_i.wdata : bus_data_low_reg_r;
  wire [63:0] start_wdata = {bus_data_high_reg_r, start_low};
  wire [3:0] size_bytes = 4'h1 << ctrl_i.access[1:0];
  wire [31:0] cur_bytes = {28'h0, 4'h1 << sb_req_r.size[1:0]};
  wire [31:0] align_mask = {28'h0, size_bytes - 4'h1};
  wire size_bad = ctrl_i.access > ACCESS_MAX;
  wire align_bad = (start_addr & align_mask) != 32'h0;

  // ==========================================================
  // closely coupled and controller ranges
  logic [REGION_COUNT-1:0][31:0] region_base;
  logic [REGION_COUNT-1:0][31:0] region_mask;
  logic [REGION_COUNT-1:0] region_hit;
  assign region_base = {interrupt_controller_range_base, closely_coupled_data_memory_base,
    closely_coupled_instruction_memory_base};
  assign region_mask = {interrupt_controller_range_mask, closely_coupled_data_memory_mask,
    closely_coupled_instruction_memory_mask};
  genvar gi;
  generate
    for (gi = 0; gi < REGION_COUNT; gi++) begin : g_region
      assign region_hit[gi] = (start_addr & region_mask[gi]) == region_base[gi];
    end
  endgenerate
  wire region_bad = |region_hit;
  wire start_ok = want && !size_bad && !align_bad && !region_bad;
  wire [2:0] start_err = size_bad ? ERR_SIZE :
    align_bad ? ERR_ALIGNMENT :
    region_bad ? ERR_BAD_ADDRESS : ERR_NONE;

  // ==========================================================
  // completion
  wire done = busy && sb_rsp_i.ack;
  wire done_ok = done && !sb_rsp_i.err;
  wire [31:0] stepped_addr = bus_address_reg_r + cur_bytes;

  // ==========================================================
  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DSB_IDLE: begin
        if (start_ok) begin
          state_nxt = DSB_BUSY;
        end
      end
      DSB_BUSY: begin
        if (sb_rsp_i.ack) begin
          state_nxt = DSB_IDLE;
        end
      end
      default: begin
        state_nxt = DSB_IDLE;
      end
    endcase
  end

  wire [2:0] error_nxt = (want && !start_ok) ? start_err :
    (done && sb_rsp_i.err) ? ERR_BAD_ADDRESS :
    error_clr_i ? ERR_NONE : error_r;
  wire busy_error_nxt = set_busy_error || (busy_error_r && !busy_error_clr_i);

  // ==========================================================
  // sequencing and status flops
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= DSB_IDLE;
      busy_error_r <= 1'b0;
      error_r <= ERR_NONE;
    end else begin
      state_r <= state_nxt;
      busy_error_r <= busy_error_nxt;
      error_r <= error_nxt;
    end
  end

  // ==========================================================
  // address register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bus_address_reg_r <= RST_ADDRESS;
    end else if (done_ok && ctrl_i.auto_inc) begin
      bus_address_reg_r <= stepped_addr;
    end else if (addr_wr && !busy) begin
      bus_address_reg_r <= dmi_req_i.wdata;
    end
  end

  // ==========================================================
  // data registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bus_data_low_reg_r <= RST_DATA;
      bus_data_high_reg_r <= RST_DATA;
    end else if (done_ok && !sb_req_r.write) begin
      bus_data_low_reg_r <= sb_rsp_i.rdata[31:0];
      bus_data_high_reg_r <= sb_rsp_i.rdata[63:32];
    end else if (!busy && dmi_req_i.write) begin
      if (hit_low) begin
        bus_data_low_reg_r <= dmi_req_i.wdata;
      end
      if (hit_high) begin
        bus_data_high_reg_r <= dmi_req_i.wdata;
      end
    end
  end

  // ==========================================================
  // bus master request, held until acknowledged
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sb_req_r <= '0;
    end else if (start_ok) begin
      sb_req_r.req <= 1'b1;
      sb_req_r.write <= want_write;
      sb_req_r.size <= ctrl_i.access;
      sb_req_r.addr <= start_addr;
      sb_req_r.wdata <= start_wdata;
    end else if (done) begin
      sb_req_r.req <= 1'b0;
    end
  end

  // ==========================================================
  // debug interface read answer
  wire [31:0] rd_mux = hit_addr ? bus_address_reg_r :
    hit_low ? bus_data_low_reg_r :
    hit_high ? bus_data_high_reg_r : UNMAPPED_DATA;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dmi_rsp_r <= '0;
    end else begin
      dmi_rsp_r.valid <= dmi_req_i.valid;
      dmi_rsp_r.rdata <= dmi_req_i.write ? UNMAPPED_DATA : rd_mux;
    end
  end

  assign dmi_rsp_o = dmi_rsp_r;
  assign sb_req_o = sb_req_r;
  assign stat_o = {busy, busy_error_r, error_r};

  // ==========================================================
  // checks
  property p_busy_start;
    @(posedge clock_i) disable iff (rst_i)
    start_ok |=> stat_o.busy && sb_req_o.req;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not set");

  property p_busy_held;
    @(posedge clock_i) disable iff (rst_i)
    (stat_o.busy && !sb_rsp_i.ack) |=> stat_o.busy && sb_req_o.req;
  endproperty
  a_busy_held: assert property (p_busy_held) else $error("busy not held");

  property p_busy_release;
    @(posedge clock_i) disable iff (rst_i)
    (stat_o.busy && sb_rsp_i.ack) |=> !stat_o.busy && !sb_req_o.req;
  endproperty
  a_busy_release: assert property (p_busy_release) else $error("busy not released");

  property p_rsp_valid;
    @(posedge clock_i) disable iff (rst_i)
    dmi_req_i.valid |=> dmi_rsp_o.valid;
  endproperty
  a_rsp_valid: assert property (p_rsp_valid) else $error("no interface answer");

  property p_bus_error;
    @(posedge clock_i) disable iff (rst_i)
    (done && sb_rsp_i.err) |=> error_r == ERR_BAD_ADDRESS
      && $stable(bus_data_low_reg_r) && $stable(bus_address_reg_r);
  endproperty
  a_bus_error: assert property (p_bus_error) else $error("failed read loaded");

  property p_read_on_data;
    @(posedge clock_i) disable iff (rst_i)
    (low_rd && ctrl_i.read_on_data && start_ok) |=> sb_req_o.req && !sb_req_o.write
      && sb_req_o.addr == $past(bus_address_reg_r);
  endproperty
  a_read_on_data: assert property (p_read_on_data) else $error("no read on data");

  property p_read_loads;
    @(posedge clock_i) disable iff (rst_i)
    (done_ok && !sb_req_o.write) |=> !stat_o.busy
      && bus_data_low_reg_r == $past(sb_rsp_i.rdata[31:0])
      && bus_data_high_reg_r == $past(sb_rsp_i.rdata[63:32]);
  endproperty
  a_read_loads: assert property (p_read_loads) else $error("read data not loaded");

  property p_violation;
    @(posedge clock_i) disable iff (rst_i)
    ((hit_low || hit_high) && stat_o.busy) |=> stat_o.busy_error;
  endproperty
  a_violation: assert property (p_violation) else $error("busy violation missed");

  property p_high_quiet;
    @(posedge clock_i) disable iff (rst_i)
    (hit_high && !sb_req_o.req) |=> !sb_req_o.req;
  endproperty
  a_high_quiet: assert property (p_high_quiet) else $error("high access started bus");

  property p_gate;
    @(posedge clock_i) disable iff (rst_i)
    ((error_r != ERR_NONE || busy_error_r) && !sb_req_o.req) |=> !sb_req_o.req;
  endproperty
  a_gate: assert property (p_gate) else $error("access despite error");

  property p_autostep;
    @(posedge clock_i) disable iff (rst_i)
    (done_ok && ctrl_i.auto_inc) |=>
      bus_address_reg_r == $past(bus_address_reg_r) + $past(cur_bytes);
  endproperty
  a_autostep: assert property (p_autostep) else $error("address not stepped");

  property p_low_write;
    @(posedge clock_i) disable iff (rst_i)
    (low_wr && !stat_o.busy && gate_open && start_ok) |=> sb_req_o.req && sb_req_o.write
      && sb_req_o.wdata[31:0] == $past(dmi_req_i.wdata)
      && sb_req_o.wdata[63:32] == bus_data_high_reg_r;
  endproperty
  a_low_write: assert property (p_low_write) else $error("low write not issued");

  property p_read_on_addr;
    @(posedge clock_i) disable iff (rst_i)
    (addr_wr && ctrl_i.read_on_addr && start_ok) |=> sb_req_o.req && !sb_req_o.write
      && sb_req_o.addr == $past(dmi_req_i.wdata) && bus_address_reg_r == sb_req_o.addr;
  endproperty
  a_read_on_addr: assert property (p_read_on_addr) else $error("no read on addr");

  property p_region_blocked;
    @(posedge clock_i) disable iff (rst_i)
    (want && region_bad && !size_bad && !align_bad) |=> !sb_req_o.req
      && error_r == ERR_BAD_ADDRESS;
  endproperty
  a_region_blocked: assert property (p_region_blocked) else $error("region reached");
endmodule
`default_nettype wire

// ==== rtl/dsb_pkg.sv ====
// shared constants and carrier types for the system bus access block
package dsb_pkg;
  // ==========================================================
  // register map on the debug module interface
  localparam int DMI_AW = 7;
  localparam logic [DMI_AW-1:0] ADDR_BUS_ADDRESS = 7'h39;
  localparam logic [DMI_AW-1:0] ADDR_DATA_LOW = 7'h3C;
  localparam logic [DMI_AW-1:0] ADDR_DATA_HIGH = 7'h3D;
  localparam logic [31:0] RST_ADDRESS = 32'h0;
  localparam logic [31:0] RST_DATA = 32'h0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0;
  // ==========================================================
  // error codes and access sizes
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_BAD_ADDRESS = 3'h2;
  localparam logic [2:0] ERR_ALIGNMENT = 3'h3;
  localparam logic [2:0] ERR_SIZE = 3'h4;
  localparam logic [2:0] ACCESS_MAX = 3'h3;
  localparam int REGION_COUNT = 3;
  // ==========================================================
  // states and carriers
  typedef enum logic [0:0] {
    DSB_IDLE,
    DSB_BUSY
  } dsb_state_e;
  typedef struct packed {
    logic valid;
    logic write;
    logic [DMI_AW-1:0] addr;
    logic [31:0] wdata;
  } dsb_dmi_req_s;
  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } dsb_dmi_rsp_s;
  typedef struct packed {
    logic req;
    logic write;
    logic [2:0] size;
    logic [31:0] addr;
    logic [63:0] wdata;
  } dsb_sb_req_s;
  typedef struct packed {
    logic ack;
    logic err;
    logic [63:0] rdata;
  } dsb_sb_rsp_s;
  typedef struct packed {
    logic read_on_addr;
    logic [2:0] access;
    logic auto_inc;
    logic read_on_data;
  } dsb_ctrl_s;
  typedef struct packed {
    logic busy;
    logic busy_error;
    logic [2:0] error;
  } dsb_stat_s;
endpackage

// ==== bench/dsb_sb_mem.sv ====
// system bus memory model answering the block's bus master
`timescale 1ns/1ns
`default_nettype none
module dsb_sb_mem (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire dsb_pkg::dsb_sb_req_s sb_req_i,
  output var dsb_pkg::dsb_sb_rsp_s sb_rsp_o,
  output logic [31:0] wr_addr_o,
  output logic [63:0] wr_data_o,
  output logic [15:0] acc_cnt_o
);
  import dsb_pkg::*;
  logic [1:0] wait_r;
  logic [1:0] lat_r;
  // ==========================================================
  // one access at a time, latency varies access to access
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sb_rsp_o <= '0;
      wait_r <= '0;
      lat_r <= '0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
      acc_cnt_o <= '0;
    end else begin
      sb_rsp_o.ack <= 1'b0;
      sb_rsp_o.err <= 1'b0;
      sb_rsp_o.rdata <= ~sb_rsp_o.rdata;
      if (sb_req_i.req && !sb_rsp_o.ack) begin
        if (wait_r != 2'h0) begin
          wait_r <= wait_r - 2'h1;
        end else begin
          sb_rsp_o.ack <= 1'b1;
          sb_rsp_o.err <= sb_req_i.addr[31:28] == 4'hB;
          sb_rsp_o.rdata <= {~sb_req_i.addr, sb_req_i.addr};
          acc_cnt_o <= acc_cnt_o + 16'h1;
          lat_r <= lat_r + 2'h1;
          wait_r <= lat_r + 2'h1;
          if (sb_req_i.write) begin
            wr_addr_o <= sb_req_i.addr;
            wr_data_o <= sb_req_i.wdata;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/debug_system_bus_access_tb.sv ====
// self-checking bench for the system bus access block
`timescale 1ns/1ns
`default_nettype none
module debug_system_bus_access_tb;
  import dsb_pkg::*;
  // ==========================================================
  // clock, design and bus model
  logic clock_i = 0;
  logic rst_i = 1;
  logic be_clr = 0;
  logic er_clr = 0;
  dsb_dmi_req_s req = '0;
  dsb_dmi_rsp_s rsp;
  dsb_ctrl_s ctrl = '0;
  dsb_stat_s stat;
  dsb_sb_req_s sbq;
  dsb_sb_rsp_s sbr;
  logic [31:0] wa;
  logic [63:0] wd;
  logic [15:0] acc;
  int error_cnt = 0;
  int checked = 0;
  logic [31:0] seed = 32'hFCB89FE8;
  logic [32:0] expq[$];
  initial forever #5 clock_i = ~clock_i;
  dsb_bus_access u_dut (.clock_i(clock_i), .rst_i(rst_i), .dmi_req_i(req), .dmi_rsp_o(rsp),
    .ctrl_i(ctrl), .busy_error_clr_i(be_clr), .error_clr_i(er_clr), .stat_o(stat),
    .sb_req_o(sbq), .sb_rsp_i(sbr));
  dsb_sb_mem u_mem (.clock_i(clock_i), .rst_i(rst_i), .sb_req_i(sbq), .sb_rsp_o(sbr),
    .wr_addr_o(wa), .wr_data_o(wd), .acc_cnt_o(acc));
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic dmi(logic w, logic [6:0] a, logic [31:0] d, logic [31:0] e, logic c = 1);
    @(posedge clock_i);
    #1;
    req = {1'b1, w, a, d};
    expq.push_back({c, e});
    @(posedge clock_i);
    #1;
    req.valid = 1'b0;
  endtask
  task automatic idle();
    int i;
    for (i = 0; i < 50 && stat.busy !== 1'b0; i++) begin
      @(posedge clock_i);
      #1;
    end
    if (i == 50) begin
      error_cnt++;
      $display("Error at %0t: busy timeout", $time);
      end_of_test();
    end
  endtask
  task automatic pulse(ref logic s);
    @(posedge clock_i);
    #1;
    s = 1'b1;
    @(posedge clock_i);
    #1;
    s = 1'b0;
  endtask
  // ==========================================================
  // response watcher
  always @(posedge clock_i) begin
    logic [32:0] n;
    if (rsp.valid === 1'b1) begin
      n = expq.size() ? expq.pop_front() : 33'h1DEADBEEF;
      if (n[32]) chk(64'(rsp.rdata), 64'(n[31:0]));
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    logic [31:0] a, h, l;
    logic [63:0] v, m;
    int e0;
    logic [31:0] ea[4] = '{32'h10000000, 32'h10000002, 32'hE0000010, 32'hB0000000};
    logic [2:0] es[4] = '{3'h5, 3'h2, 3'h2, 3'h2};
    logic [2:0] ee[4] = '{ERR_SIZE, ERR_ALIGNMENT, ERR_BAD_ADDRESS, ERR_BAD_ADDRESS};
    repeat (8) @(posedge clock_i);
    #1;
    rst_i = 0;
    dmi(0, ADDR_BUS_ADDRESS, 0, RST_ADDRESS);
    dmi(0, ADDR_DATA_LOW, 0, RST_DATA);
    dmi(0, ADDR_DATA_HIGH, 0, RST_DATA);
    dmi(0, 7'h10, 0, UNMAPPED_DATA);
    for (int k = 0; k < 4; k++) begin
      ctrl = '{1'b0, 3'(k), 1'b1, 1'b0};
      m = {64{1'b1}} >> (64 - (8 << k));
      h = rnd();
      l = rnd();
      a = rnd() & 32'h0FFFFFF8 | 32'h10000000;
      e0 = acc;
      dmi(1, ADDR_DATA_HIGH, h, 0);
      dmi(1, ADDR_BUS_ADDRESS, a, 0);
      dmi(1, ADDR_DATA_LOW, l, 0);
      chk(64'(stat.busy), 1);
      idle();
      chk(64'(wa), 64'(a));
      chk(wd & m, {h, l} & m);
      chk(64'(acc), 64'(e0 + 1));
      chk(64'(sbq.size), 64'(k));
      dmi(0, ADDR_BUS_ADDRESS, 0, a + (32'h1 << k));
      dmi(0, ADDR_DATA_HIGH, 0, h);
    end
    dmi(1, ADDR_DATA_LOW, l, 0);
    dmi(1, ADDR_DATA_HIGH, ~h, 0);
    idle();
    chk(64'(stat.busy_error), 1);
    e0 = acc;
    dmi(1, ADDR_DATA_LOW, l, 0);
    chk(64'(sbq.req), 0);
    chk(64'(acc), 64'(e0));
    pulse(be_clr);
    chk(64'(stat.busy_error), 0);
    dmi(0, ADDR_DATA_HIGH, 0, h);
    ctrl = '{1'b1, 3'h3, 1'b1, 1'b0};
    v = {~a, a};
    dmi(1, ADDR_BUS_ADDRESS, a, 0);
    idle();
    dmi(0, ADDR_DATA_HIGH, 0, v[63:32]);
    dmi(0, ADDR_DATA_LOW, 0, v[31:0]);
    ctrl = '{1'b0, 3'h2, 1'b1, 1'b1};
    dmi(0, ADDR_DATA_LOW, 0, v[31:0]);
    idle();
    ctrl.read_on_data = 1'b0;
    v = {~(a + 8), a + 8};
    dmi(0, ADDR_DATA_HIGH, 0, 0, 0);
    dmi(0, ADDR_DATA_LOW, 0, v[31:0]);
    dmi(0, ADDR_BUS_ADDRESS, 0, a + 12);
    for (int k = 0; k < 4; k++) begin
      ctrl = '{1'b0, es[k], 1'b0, 1'b0};
      e0 = acc;
      dmi(1, ADDR_BUS_ADDRESS, ea[k], 0);
      dmi(1, ADDR_DATA_LOW, 0, 0);
      idle();
      dmi(1, ADDR_DATA_LOW, 0, 0);
      idle();
      chk(64'(stat.error), 64'(ee[k]));
      chk(64'(acc), 64'(e0 + (k == 3)));
      pulse(er_clr);
      chk(64'(stat.error), 64'(ERR_NONE));
    end
    repeat (3) @(posedge clock_i);
    end_of_test();
  end
endmodule
`default_nettype wire
